// ===== design/xid_map.svh
// Constants for the exclusive-OR instruction datapath
`ifndef XID_MAP_SVH
`define XID_MAP_SVH
`define XID_OP_IMM      6'h3a
`define XID_OP_REG      6'h06
`define XID_OP_MSB      13
`define XID_OP_LSB      8
`define XID_DEST_BIT    7
`define XID_ADDR_MSB    6
`define XID_IMM_MSB     7
`define XID_W_RESET     8'h00
`define XID_Z_RESET     1'b0
`endif

// ===== design/xid_pkg.sv
// Types for the exclusive-OR instruction datapath
package xid_pkg;
  typedef enum logic [2:0] {
    XID_NONE = 3'b001,
    XID_IMM  = 3'b010,
    XID_REG  = 3'b100
  } xid_op_t;
endpackage

// ===== design/xid_decode.sv
// Instruction decoder for the two exclusive-OR forms
`timescale 1ns/100ps
`include "xid_map.svh"
module xid_decode
  import xid_pkg::*;
(
  // Instruction
  input  wire logic [13:0] instr,
  // Decoded fields
  output xid_op_t          op,
  output logic             dest_file,
  output logic [6:0]       addr,
  output logic [7:0]       imm
);
  wire [5:0] opc = instr[`XID_OP_MSB:`XID_OP_LSB];
  assign op        = (opc == `XID_OP_IMM) ? XID_IMM :
                     (opc == `XID_OP_REG) ? XID_REG : XID_NONE;
  assign dest_file = instr[`XID_DEST_BIT];
  assign addr      = instr[`XID_ADDR_MSB:0];
  assign imm       = instr[`XID_IMM_MSB:0];
endmodule

// ===== design/xid_datapath.sv
// Exclusive-OR instruction datapath: accumulator, zero flag, file write-back
// Contract
// [RULE1] Opcode 111010 with 8-bit immediate: XOR accumulator with immediate.
// [RULE2] Immediate form writes accumulator only, never data memory.
// [RULE3] Opcode 000110 with dest bit and 7-bit address: XOR accumulator with file.
// [RULE4] Register form, dest 0: result to accumulator, file unchanged.
// [RULE5] Register form, dest 1: result to file, accumulator unchanged.
// [RULE6] One word, one cycle; zero flag follows result, other flags untouched.
`timescale 1ns/100ps
`include "xid_map.svh"
module xid_datapath
  import xid_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Instruction issue
  input  wire logic        instr_valid,
  input  wire logic [13:0] instr,
  // File register read operand (combinational from register file)
  output logic [6:0]       file_raddr,
  input  wire logic [7:0]  file_rdata,
  // File register write-back
  output logic             file_we,
  output logic [6:0]       file_waddr,
  output logic [7:0]       file_wdata,
  // Architectural state
  output logic [7:0]       acc,
  output logic             zero_flag,
  output logic             done
);
  import xid_pkg::*;

  xid_op_t    op;
  logic       dest_file;
  logic [6:0] addr;
  logic [7:0] imm;

  xid_decode u_dec (
    .instr     (instr),
    .op        (op),
    .dest_file (dest_file),
    .addr      (addr),
    .imm       (imm)
  );

  // Read address is combinational so the operand arrives in the issue cycle
  assign file_raddr = addr;

  wire       go_imm  = instr_valid && (op == XID_IMM);
  wire       go_reg  = instr_valid && (op == XID_REG);
  // [RULE1] Immediate operand
  // [RULE3] File operand
  wire [7:0] operand = go_imm ? imm : file_rdata;
  wire [7:0] result  = acc ^ operand;
  // [RULE2] Accumulator write
  // [RULE4] Dest zero to accumulator
  wire       next_acc_we  = go_imm || (go_reg && !dest_file);
  // [RULE5] Dest one to file
  wire       next_file_we = go_reg && dest_file;
  // [RULE6] Zero flag update
  wire       next_zero_we = go_imm || go_reg;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      acc        <= `XID_W_RESET;
      zero_flag  <= `XID_Z_RESET;
      file_we    <= 1'b0;
      file_waddr <= 7'h00;
      file_wdata <= 8'h00;
      done       <= 1'b0;
    end
    else
    begin
      if (next_acc_we)
        acc <= result;
      if (next_zero_we)
        zero_flag <= (result == 8'h00);
      // Write-back registered: outputs valid one edge after issue, register file commits on the second edge
      file_we    <= next_file_we;
      file_waddr <= addr;
      file_wdata <= result;
      done       <= next_zero_we;
    end
  end

  // Assertions
  imm_result_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE1
    go_imm |=> acc == ($past(acc) ^ $past(instr[7:0])))
    else $error("immediate xor result wrong");
  imm_nowrite_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE2
    go_imm |=> !file_we)
    else $error("immediate form wrote file");
  reg_result_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE3
    (go_reg && dest_file) |=> file_wdata == ($past(acc) ^ $past(file_rdata)) && file_waddr == $past(instr[6:0]))
    else $error("file xor result wrong");
  dest_acc_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE4
    (go_reg && !dest_file) |=> !file_we && acc == ($past(acc) ^ $past(file_rdata)))
    else $error("dest zero misrouted");
  dest_file_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE5
    (go_reg && dest_file) |=> file_we && $stable(acc))
    else $error("dest one misrouted");
  zero_flag_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE6
    (go_imm || go_reg) |=> done && zero_flag == ((($past(acc) ^ $past(go_imm ? imm : file_rdata))) == 8'h00))
    else $error("zero flag wrong");
  idle_hold_a: assert property (@(posedge clk_sys) disable iff (rst) // RULE6
    !(go_imm || go_reg) |=> $stable(acc) && $stable(zero_flag) && !done && !file_we)
    else $error("state changed without xor");

  imm_c:   cover property (@(posedge clk_sys) disable iff (rst) go_imm ##1 zero_flag);
  racc_c:  cover property (@(posedge clk_sys) disable iff (rst) go_reg && !dest_file);
  rfile_c: cover property (@(posedge clk_sys) disable iff (rst) go_reg && dest_file ##1 go_imm);
endmodule

// ===== verification/xor_instruction_datapath_test.sv
// Self-checking bench for the exclusive-OR datapath
`timescale 1ns/100ps
`include "xid_map.svh"
module xor_instruction_datapath_test;
  import xid_pkg::*;
  logic        clk_sys = 0;
  logic        rst = 1;
  logic        instr_valid = 0;
  logic [13:0] instr = 0;
  logic [6:0]  file_raddr, file_waddr;
  logic [7:0]  file_rdata, file_wdata, acc;
  logic        file_we, zero_flag, done;
  logic [7:0]  mem [128];
  int          m_acc, m_z, m_mem [128], err_total, cmp_count, v;
  always #4 clk_sys = ~clk_sys;
  // Forwarding, since a write lands one edge late
  assign file_rdata = (file_we === 1'b1 && file_waddr === file_raddr) ? file_wdata : mem[file_raddr];
  always @(posedge clk_sys) if (file_we === 1'b1) mem[file_waddr] <= file_wdata;
  xid_datapath dut (.clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .file_raddr(file_raddr), .file_rdata(file_rdata), .file_we(file_we), .file_waddr(file_waddr),
    .file_wdata(file_wdata), .acc(acc), .zero_flag(zero_flag), .done(done));
  task results;
    if (err_total == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Model runs one word per cycle, back to back
  task step(input logic vld, input logic [13:0] w);
    logic [7:0] r;
    logic       hit, wf;
    instr_valid = vld;
    instr = w;
    #1;
    chk(file_raddr, w[6:0]);
    r = m_acc ^ (w[13:8] == `XID_OP_IMM ? w[7:0] : m_mem[w[6:0]]);
    hit = vld && (w[13:8] == `XID_OP_IMM || w[13:8] == `XID_OP_REG);
    wf = hit && w[13:8] == `XID_OP_REG && w[7];
    if (wf) m_mem[w[6:0]] = r;
    else if (hit) m_acc = r;
    if (hit) m_z = (r == 0);
    @(negedge clk_sys);
    chk(done, hit);
    chk(file_we, wf);
    if (wf) chk(file_waddr, w[6:0]);
    if (wf) chk(file_wdata, r);
    chk(acc, m_acc);
    chk(zero_flag, m_z);
  endtask
  initial
  begin
    void'($urandom(15));
    for (int i = 0; i < 128; i++)
    begin
      mem[i] = $urandom;
      m_mem[i] = mem[i];
    end
    repeat (2) @(negedge clk_sys);
    rst = 0;
    step(1, {`XID_OP_IMM, 8'hb5});
    step(1, {`XID_OP_IMM, 8'haf});
    step(1, {`XID_OP_IMM, 8'h1a});
    step(1, {`XID_OP_REG, 8'hff});
    step(1, {`XID_OP_REG, 8'h7f});
    step(0, {`XID_OP_REG, 8'h80});
    rst = 1;
    @(negedge clk_sys);
    chk(acc, `XID_W_RESET);
    chk(zero_flag, `XID_Z_RESET);
    chk(done, 0);
    chk(file_we, 0);
    rst = 0;
    m_acc = `XID_W_RESET;
    m_z = `XID_Z_RESET;
    step(1, {`XID_OP_IMM, 8'h00});
    for (int i = 0; i < 400; i++)
    begin
      v = $urandom % 4;
      step($urandom % 8 != 0, v == 0 ? {`XID_OP_IMM, 8'($urandom)} :
        v < 3 ? {`XID_OP_REG, 8'($urandom)} : {2'b01, 12'($urandom)});
    end
    results();
  end
  initial
  begin
    #8000;
    err_total++;
    results();
  end
endmodule
